// ### rtl/pport_params.svh
// Offsets, field positions, reset values and timing counts of printer port.
// Assumes a single core clock whose period is given below in nanoseconds.
`ifndef PPORT_PARAMS_SVH
`define PPORT_PARAMS_SVH

`define CLK_PERIOD_NS 50
`define RST_MIN_NS 40
`define RST_MIN_CYC (((`RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define ACC_WAIT_NS 150
`define ACC_WAIT_CYC (((`ACC_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))

`define REG_DATA 2'h0
`define REG_STAT 2'h1
`define REG_CTRL 2'h2
`define REG_MODE 2'h3

`define CTL_STROBE 0
`define CTL_AUTO_LINE_FEED_N 1
`define CTL_INIT 2
`define CTL_SELECT 3
`define CTL_DIR_IN 5
`define MODE_FLOAT 2

`define CTRL_RST 8'h00
`define MODE_RST 8'h00
`define DATA_RST 8'h00

`endif

// ### rtl/pport_pkg.sv
// Types shared by the printer port modules.
// Assumes nothing beyond a SystemVerilog compiler.
package pport_pkg;

    typedef enum logic [1:0] {
        MODE_COMPAT = 2'b00,
        MODE_BIDIR = 2'b01,
        MODE_FIFO = 2'b10,
        MODE_ECP = 2'b11
    } port_mode_t;

    typedef enum logic {
        TMR_IDLE = 1'b0,
        TMR_COUNT = 1'b1
    } tmr_state_t;

endpackage

// ### rtl/port_timer_if.sv
// Start, load and status signals between the port logic and its wait timer.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface port_timer_if #(parameter int W = 8);
    logic start;
    logic [W-1:0] load;
    logic busy;
    logic done;
    modport timer (input start, input load, output busy, output done);
    modport user (output start, output load, input busy, input done);
endinterface

// ### rtl/port_wait_timer.sv
// Down counter that stays busy for a loaded number of cycles.
// Assumes a load value of at least one.
`timescale 1ns/1ps
module port_wait_timer
    import pport_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Timer carrier.
    port_timer_if.timer tmr
);
    tmr_state_t state_r;
    tmr_state_t state_nxt;
    logic [$bits(tmr.load)-1:0] cnt_r;
    logic [$bits(tmr.load)-1:0] cnt_nxt;
    logic last_w;

    assign last_w = (cnt_r == {{($bits(cnt_r)-1){1'b0}}, 1'b1});
    assign tmr.busy = (state_r == TMR_COUNT);
    assign tmr.done = (state_r == TMR_COUNT) && last_w && !tmr.start;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            TMR_IDLE: begin
                if (tmr.start) begin
                    state_nxt = TMR_COUNT;
                    cnt_nxt = tmr.load;
                end
            end
            TMR_COUNT: begin
                if (tmr.start) begin
                    cnt_nxt = tmr.load;
                end else if (last_w) begin
                    state_nxt = TMR_IDLE;
                    cnt_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r - 1'b1;
                end
            end
            default: begin
                state_nxt = TMR_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_r <= TMR_IDLE;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ### rtl/printer_port_pins.sv
// Pin logic of the bidirectional printer port and its host-side handshakes.
// Assumes all inputs synchronous to ref_clk_i; pads resolve the enables.
`timescale 1ns/1ps
`include "pport_params.svh"

// Notes on behaviour
// - Channel-ready is driven low while a data access needs extra clocks.
// - Reset held at least 40 ns returns registers and outputs to defaults.
// - Direction flag is low for output operation and high for input.
// - Eight data lines, three-state, line 0 least significant.
// - Auto-line-feed is a three-state active-low general-purpose line.
// - Printer initialise is an active-low three-state output.
// - Select line read at command bit 3, written at control bit 3.
// - Data strobe is active low and marks valid data on the bus.
// - DMA request and acknowledge serve only FIFO and extended modes.
// - Port registers are chosen by the two lowest host address bits.
module printer_port_pins
    import pport_pkg::*;
#(
    parameter int WAIT_CYC = `ACC_WAIT_CYC
)(
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Host access port.
    input wire logic [1:0] host_addr_i,
    input wire logic host_rd_n_i,
    input wire logic host_wr_n_i,
    input wire logic [7:0] host_wdata_i,
    output logic [7:0] host_rdata_o,
    output logic host_rdata_oe_o,
    output logic iochrdy_o,
    output logic iochrdy_oe_o,
    // DMA handshake.
    output logic dreq_o,
    output logic dreq_oe_o,
    input wire logic dack_n_i,
    input wire logic tc_i,
    // Parallel data and direction.
    input wire logic [7:0] par_data_bus_i,
    output logic [7:0] par_data_bus_o,
    output logic par_data_bus_oe_o,
    output logic port_direction_flag_o,
    // Printer control lines.
    input wire logic strobe_n_i,
    output logic strobe_n_o,
    output logic strobe_n_oe_o,
    input wire logic auto_line_feed_n_i,
    output logic auto_line_feed_n_o,
    output logic auto_line_feed_n_oe_o,
    input wire logic printer_choose_n_i,
    output logic printer_choose_n_o,
    output logic printer_choose_n_oe_o,
    output logic init_n_o,
    output logic init_n_oe_o,
    // Printer status lines.
    input wire logic ack_n_i,
    input wire logic busy_i,
    input wire logic fault_n_i,
    input wire logic paper_empty_i,
    input wire logic online_n_i
);
    // Refuses wait counts that the eight-bit timer cannot hold.
    if (WAIT_CYC < 1 || WAIT_CYC > 255) begin : g_bad_wait
        $error("WAIT_CYC must lie between 1 and 255.");
    end

    port_timer_if #(.W(8)) tmr ();

    port_wait_timer u_timer (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .tmr(tmr)
    );

    logic rd_n_q_r;
    logic wr_n_q_r;
    logic [7:0] wdata_r;
    logic [7:0] data_r;
    logic [7:0] ctrl_r;
    logic [7:0] mode_r;
    logic tc_seen_r;
    logic [7:0] rdata_nxt;
    logic wait_nxt;
    logic dir_nxt;

    wire port_mode_t mode_w = port_mode_t'(mode_r[1:0]);
    wire dma_mode_w = (mode_w == MODE_FIFO) || (mode_w == MODE_ECP);
    wire rd_start_w = rd_n_q_r && !host_rd_n_i;
    wire wr_start_w = wr_n_q_r && !host_wr_n_i;
    wire wr_commit_w = !wr_n_q_r && host_wr_n_i;
    wire dma_cyc_w = dma_mode_w && !dack_n_i;
    wire sel_data_w = (host_addr_i == `REG_DATA) || dma_cyc_w;
    wire wr_data_w = wr_commit_w && sel_data_w;
    wire wr_ctrl_w = wr_commit_w && !dma_cyc_w && host_addr_i == `REG_CTRL;
    wire wr_mode_w = wr_commit_w && !dma_cyc_w && host_addr_i == `REG_MODE;
    wire tc_hit_w = dma_cyc_w && tc_i;
    wire float_w = mode_r[`MODE_FLOAT];

    // The timer holds channel ready low for WAIT_CYC + 1 cycles on every data access.
    assign tmr.start = (rd_start_w || wr_start_w) && sel_data_w;
    assign tmr.load = 8'(WAIT_CYC);
    assign wait_nxt = tmr.start || tmr.busy;

    // Compatible mode always drives; other modes follow control bit 5.
    assign dir_nxt = (mode_w != MODE_COMPAT)
                     && ctrl_r[`CTL_DIR_IN];

    // Read selection by the two low address bits.
    wire [7:0] stat_w = {busy_i, ack_n_i, paper_empty_i, online_n_i,
                         fault_n_i, 3'h0};
    wire [7:0] cmd_w = {2'h0, port_direction_flag_o, 1'b0,
                        !printer_choose_n_i, !init_n_o,
                        !auto_line_feed_n_i, !strobe_n_i};
    always_comb begin
        rdata_nxt = 8'h00;
        case (host_addr_i)
            `REG_DATA: rdata_nxt = par_data_bus_i;
            `REG_STAT: rdata_nxt = stat_w;
            `REG_CTRL: rdata_nxt = cmd_w;
            `REG_MODE: rdata_nxt = mode_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rd_n_q_r <= 1'b1;
            wr_n_q_r <= 1'b1;
            wdata_r <= `DATA_RST;
        end else begin
            rd_n_q_r <= host_rd_n_i;
            wr_n_q_r <= host_wr_n_i;
            if (!host_wr_n_i) begin
                wdata_r <= host_wdata_i;
            end
        end
    end

    // Registers; all return to defaults under reset.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            data_r <= `DATA_RST;
            ctrl_r <= `CTRL_RST;
            mode_r <= `MODE_RST;
            tc_seen_r <= 1'b0;
        end else begin
            if (wr_data_w) begin
                data_r <= wdata_r;
            end
            if (wr_ctrl_w) begin
                ctrl_r <= wdata_r;
            end
            if (wr_mode_w) begin
                mode_r <= wdata_r;
            end
            if (tc_hit_w) begin
                tc_seen_r <= 1'b1;
            end else if (wr_mode_w) begin
                tc_seen_r <= 1'b0;
            end
        end
    end

    // Every output comes from a flip-flop.
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            host_rdata_o <= 8'h00;
            host_rdata_oe_o <= 1'b0;
            iochrdy_o <= 1'b1;
            iochrdy_oe_o <= 1'b0;
            dreq_o <= 1'b0;
            dreq_oe_o <= 1'b0;
            par_data_bus_o <= `DATA_RST;
            par_data_bus_oe_o <= 1'b1;
            port_direction_flag_o <= 1'b0;
            strobe_n_o <= 1'b1;
            strobe_n_oe_o <= 1'b1;
            auto_line_feed_n_o <= 1'b1;
            auto_line_feed_n_oe_o <= 1'b1;
            printer_choose_n_o <= 1'b1;
            printer_choose_n_oe_o <= 1'b1;
            init_n_o <= 1'b1;
            init_n_oe_o <= 1'b1;
        end else begin
            host_rdata_o <= rdata_nxt;
            host_rdata_oe_o <= !host_rd_n_i;
            iochrdy_o <= !wait_nxt;
            iochrdy_oe_o <= wait_nxt;
            dreq_o <= dma_mode_w && !tc_seen_r && !tc_hit_w;
            dreq_oe_o <= dma_mode_w;
            par_data_bus_o <= data_r;
            par_data_bus_oe_o <= !dir_nxt;
            port_direction_flag_o <= dir_nxt;
            strobe_n_o <= !ctrl_r[`CTL_STROBE];
            strobe_n_oe_o <= !float_w;
            auto_line_feed_n_o <= !ctrl_r[`CTL_AUTO_LINE_FEED_N];
            auto_line_feed_n_oe_o <= !float_w;
            printer_choose_n_o <= !ctrl_r[`CTL_SELECT];
            printer_choose_n_oe_o <= !float_w;
            init_n_o <= !ctrl_r[`CTL_INIT];
            init_n_oe_o <= !float_w;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    sequence s_wait_low;
        iochrdy_oe_o && !iochrdy_o;
    endsequence

    a_wait_starts: assert property (
        tmr.start |=> s_wait_low)
        else $error("Channel ready not pulled low on data access.");
    a_wait_ends: assert property (
        $rose(iochrdy_oe_o) |-> ##[1:300] !iochrdy_oe_o && iochrdy_o)
        else $error("Channel ready never released.");
    a_reset_defaults: assert property (
        @(posedge ref_clk_i) disable iff (1'b0)
        sys_rst_i |=> !dreq_o && !iochrdy_oe_o && !port_direction_flag_o)
        else $error("Outputs not at defaults after reset.");
    a_dir_compat: assert property (
        (mode_w == MODE_COMPAT) [*2] |-> !port_direction_flag_o)
        else $error("Direction flag high in compatible mode.");
    a_bus_floats: assert property (
        port_direction_flag_o |-> !par_data_bus_oe_o)
        else $error("Data bus driven while direction is input.");
    a_select_write: assert property (
        wr_ctrl_w && wdata_r[`CTL_SELECT] && !float_w
        |-> ##2 !printer_choose_n_o && printer_choose_n_oe_o)
        else $error("Select line not driven low by control bit 3.");
    a_select_read: assert property (
        !host_rd_n_i && host_addr_i == `REG_CTRL
        |=> host_rdata_o[3] == !$past(printer_choose_n_i))
        else $error("Command bit 3 does not show the select line.");
    a_strobe_write: assert property (
        wr_ctrl_w && wdata_r[`CTL_STROBE] |-> ##2 !strobe_n_o)
        else $error("Strobe not asserted by control bit 0.");
    a_lines_float: assert property (
        wr_mode_w && wdata_r[`MODE_FLOAT]
        |-> ##2 !auto_line_feed_n_oe_o && !init_n_oe_o)
        else $error("Control lines not released in float setting.");
    a_dreq_gated: assert property (
        !$past(dma_mode_w) |-> !dreq_o)
        else $error("DMA request outside FIFO or extended mode.");
    a_dreq_tc: assert property (
        tc_hit_w |=> !dreq_o ##1 !dreq_o)
        else $error("DMA request stays up after terminal count.");
    a_addr_mode: assert property (
        wr_mode_w |=> mode_r == $past(wdata_r))
        else $error("Mode register not written at offset 3.");
endmodule

// ### tb/printer_model.sv
// Printer model: status lines, busy and acknowledge after a strobe.
// Assumes the bench resolves the data bus from both enables.
`timescale 1ns/1ps
module printer_model (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Port side.
    input wire logic strobe_n_i,
    input wire logic dir_i,
    input wire logic [7:0] byte_i,
    input wire logic [3:0] stat_i,
    output logic [7:0] pd_o,
    output logic pd_en_o,
    output logic ack_n_o,
    output logic busy_o,
    output logic fault_n_o,
    output logic paper_empty_o,
    output logic online_n_o
);
    logic stb_r;
    logic [2:0] cnt_r;
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stb_r <= 1'b1;
            cnt_r <= 3'h0;
        end else begin
            stb_r <= strobe_n_i;
            if (stb_r && !strobe_n_i)
                cnt_r <= 3'h3;
            else if (cnt_r != 3'h0)
                cnt_r <= cnt_r - 3'h1;
        end
    end
    assign busy_o = stat_i[3] | (cnt_r > 3'h1);
    assign ack_n_o = cnt_r != 3'h1;
    assign fault_n_o = ~stat_i[0];
    assign paper_empty_o = stat_i[1];
    assign online_n_o = stat_i[2];
    assign pd_en_o = dir_i;
    assign pd_o = byte_i;
endmodule

// ### tb/printer_port_pins_tb.sv
// Bench of the printer port pins with a printer model on the far side.
// Assumes registered pins that settle within eight cycles of a write.
`timescale 1ns/1ps
module printer_port_pins_tb;
    import pport_pkg::*;
    localparam int WAIT = 3;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [1:0] host_addr_i = 2'h0;
    logic host_rd_n_i = 1'b1;
    logic host_wr_n_i = 1'b1;
    logic [7:0] host_wdata_i = 8'h00;
    logic dack_n_i = 1'b1;
    logic tc_i = 1'b0;
    logic [7:0] byte_r = 8'h00;
    logic [3:0] stat_r = 4'h0;
    logic [31:0] seed_r = 32'h00009764;
    int miscompares = 0;
    int n_tests = 0;
    logic [7:0] host_rdata_o, par_data_bus_o, pd_m, pd;
    logic host_rdata_oe_o, iochrdy_o, iochrdy_oe_o, dreq_o, dreq_oe_o;
    logic par_data_bus_oe_o, port_direction_flag_o, init_n_o, init_n_oe_o;
    logic strobe_n_o, strobe_n_oe_o, auto_line_feed_n_o;
    logic auto_line_feed_n_oe_o, printer_choose_n_o, printer_choose_n_oe_o;
    logic pd_en, ack_n, busy, fault_n, pe, online_n, stb, afd, sel;
    assign pd = par_data_bus_oe_o ? par_data_bus_o : (pd_en ? pd_m : 8'hFF);
    assign stb = strobe_n_oe_o ? strobe_n_o : 1'b1;
    assign afd = auto_line_feed_n_oe_o ? auto_line_feed_n_o : 1'b1;
    assign sel = printer_choose_n_oe_o ? printer_choose_n_o : 1'b1;
    always #25 ref_clk_i = ~ref_clk_i;
    printer_port_pins #(.WAIT_CYC(WAIT)) u_printer_port_pins (
        .ref_clk_i, .sys_rst_i, .host_addr_i, .host_rd_n_i, .host_wr_n_i,
        .host_wdata_i, .host_rdata_o, .host_rdata_oe_o, .iochrdy_o,
        .iochrdy_oe_o, .dreq_o, .dreq_oe_o, .dack_n_i, .tc_i,
        .par_data_bus_i(pd), .par_data_bus_o, .par_data_bus_oe_o,
        .port_direction_flag_o, .strobe_n_i(stb), .strobe_n_o,
        .strobe_n_oe_o, .auto_line_feed_n_i(afd), .auto_line_feed_n_o,
        .auto_line_feed_n_oe_o, .printer_choose_n_i(sel), .printer_choose_n_o,
        .printer_choose_n_oe_o, .init_n_o, .init_n_oe_o, .ack_n_i(ack_n),
        .busy_i(busy), .fault_n_i(fault_n), .paper_empty_i(pe),
        .online_n_i(online_n));
    printer_model u_printer_model (
        .ref_clk_i, .sys_rst_i, .strobe_n_i(stb),
        .dir_i(port_direction_flag_o), .byte_i(byte_r), .stat_i(stat_r),
        .pd_o(pd_m), .pd_en_o(pd_en), .ack_n_o(ack_n), .busy_o(busy),
        .fault_n_o(fault_n), .paper_empty_o(pe), .online_n_o(online_n));

    function automatic logic [31:0] rnd();
        seed_r = seed_r ^ (seed_r << 13);
        seed_r = seed_r ^ (seed_r >> 17);
        seed_r = seed_r ^ (seed_r << 5);
        return seed_r;
    endfunction

    function automatic logic [7:0] exp_stat(input logic [7:0] s);
        return {s[3], 1'b1, s[1], s[2], ~s[0], 3'h0};
    endfunction

    task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic print_verdict();
        $display("tests %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        host_addr_i <= a;
        host_wdata_i <= d;
        host_wr_n_i <= 1'b0;
        @(posedge ref_clk_i);
        host_wr_n_i <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d,
                      output logic [7:0] w, output logic e);
        w = 8'h00;
        host_addr_i <= a;
        host_rd_n_i <= 1'b0;
        repeat (10) begin
            @(posedge ref_clk_i);
            if (iochrdy_oe_o === 1'b1 && iochrdy_o === 1'b0)
                w++;
        end
        d = host_rdata_o;
        e = host_rdata_oe_o;
        host_rd_n_i <= 1'b1;
        @(posedge ref_clk_i);
    endtask

    function automatic logic [7:0] dflt();
        return {port_direction_flag_o, par_data_bus_oe_o, iochrdy_oe_o,
                iochrdy_o, dreq_oe_o, auto_line_feed_n_o,
                printer_choose_n_o, init_n_o};
    endfunction

    function automatic logic [7:0] dir_pins();
        return {6'h0, port_direction_flag_o, par_data_bus_oe_o};
    endfunction

    function automatic logic [7:0] ctl_pins();
        return {4'h0, ~printer_choose_n_o, ~init_n_o, ~auto_line_feed_n_o,
                ~strobe_n_o};
    endfunction

    initial begin
        repeat (20000) @(posedge ref_clk_i);
        miscompares++;
        print_verdict();
    end

    initial begin
        logic [7:0] v, d, w;
        logic e;
        repeat (16) @(posedge ref_clk_i);
        chk("defaults", 8'h57, dflt());
        sys_rst_i <= 1'b0;
        @(posedge ref_clk_i);
        wr(2'h3, 8'h01);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'h0F : 8'(rnd());
            v = v & 8'h0F;
            wr(2'h2, v);
            chk("ctl pins", v, ctl_pins());
            rd(2'h2, d, w, e);
            chk("cmd read", v, d & 8'h0F);
            chk("ctl wait", 8'h00, w);
            v = 8'(rnd());
            wr(2'h0, v);
            chk("pd out", v, pd);
            chk("dir out", 8'h01, dir_pins());
            v = 8'(rnd());
            byte_r <= v;
            wr(2'h2, 8'h20);
            chk("dir in", 8'h02, dir_pins());
            rd(2'h0, d, w, e);
            chk("pd in", v, d);
            chk("rd wait", 8'(WAIT + 1), w);
            chk("rd enable", 8'h01, {7'h0, e});
            v = 8'(rnd()) & 8'h0F;
            stat_r <= v[3:0];
            rd(2'h1, d, w, e);
            chk("status", exp_stat(v), d);
        end
        wr(2'h3, 8'h05);
        chk("float", 8'h00, {4'h0, init_n_oe_o, strobe_n_oe_o,
            auto_line_feed_n_oe_o, printer_choose_n_oe_o});
        wr(2'h3, 8'h00);
        chk("dreq compat", 8'h00, {6'h0, dreq_oe_o, dreq_o});
        wr(2'h3, 8'h02);
        chk("dreq fifo", 8'h03, {6'h0, dreq_oe_o, dreq_o});
        tc_i <= 1'b1;
        @(posedge ref_clk_i);
        tc_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chk("tc no dack", 8'h03, {6'h0, dreq_oe_o, dreq_o});
        dack_n_i <= 1'b0;
        tc_i <= 1'b1;
        @(posedge ref_clk_i);
        dack_n_i <= 1'b1;
        tc_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chk("tc done", 8'h02, {6'h0, dreq_oe_o, dreq_o});
        wr(2'h3, 8'h03);
        chk("dreq ecp", 8'h03, {6'h0, dreq_oe_o, dreq_o});
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        chk("defaults", 8'h57, dflt());
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk("after reset", 8'h57, dflt());
        print_verdict();
    end
endmodule
